// ### lmsg_pkg.sv
// constants, register map and memory areas of the long text output block
package lmsg_pkg;
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_SRC      = 4'h1;
  localparam logic [3:0]  ADDR_STAT     = 4'h2;
  localparam logic [3:0]  ADDR_IRQ      = 4'h3;
  localparam logic [3:0]  ADDR_MASK     = 4'h4;
  localparam int          CTRL_START    = 0;
  localparam int          CTRL_INDIR    = 1;
  localparam int          CTRL_DEST_LSB = 4;
  localparam int          STAT_BUSY     = 0;
  localparam int          STAT_FAULT    = 1;
  localparam int          STAT_SENT     = 2;
  localparam int          STAT_LEN_LSB  = 8;
  localparam int          IRQ_DONE      = 0;
  localparam int          IRQ_FAULT     = 1;
  localparam logic [3:0]  DEST_CONSOLE  = 4'h0;
  localparam logic [3:0]  DEST_SER_LEFT = 4'h1;
  localparam logic [3:0]  DEST_SER_RIGHT = 4'h2;
  localparam logic [4:0]  MSG_LAST_WORD = 5'h0F;
  localparam logic [15:0] MSG_SPAN      = 16'h000F;
  localparam logic [5:0]  MSG_CHARS     = 6'h20;
  localparam logic [7:0]  CHAR_CR       = 8'h0D;
  localparam logic [7:0]  CHAR_NUL      = 8'h00;
  // memory areas of the flat word space
  localparam logic [15:0] IR_BASE       = 16'h0000;
  localparam logic [15:0] IR_END        = 16'h00FF;
  localparam logic [15:0] HR_BASE       = 16'h0100;
  localparam logic [15:0] HR_END        = 16'h01FF;
  localparam logic [15:0] AR_BASE       = 16'h0200;
  localparam logic [15:0] AR_END        = 16'h02FF;
  localparam logic [15:0] LR_BASE       = 16'h0300;
  localparam logic [15:0] LR_END        = 16'h03FF;
  localparam logic [15:0] DATA_BASE     = 16'h1000;
  localparam logic [15:0] DATA_WORDS    = 16'h0800;
  localparam logic [15:0] DATA_END      = 16'h17FF;
  localparam logic [3:0]  RST_DEST      = 4'h0;
  localparam logic [15:0] RST_SRC       = 16'h0000;
  localparam logic [1:0]  RST_MASK      = 2'h0;
endpackage

// ### pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] level
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      level <= '0;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          level[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // pin_sync

// ### msg_buf.sv
// sixteen-word message buffer, registered read
`timescale 1ns/1ns
module msg_buf (
  input  wire logic        clk,
  input  wire logic        wrEn,
  input  wire logic [3:0]  wrAddr,
  input  wire logic [15:0] wrData,
  input  wire logic [3:0]  rdAddr,
  output logic      [15:0] rdData
);
  logic [15:0] mem [16];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // msg_buf

// ### long_text_output.sv
// long text output instruction engine with register port and char streams
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module long_text_output (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  output logic             irq,
  output logic             memRd,
  output logic      [15:0] memAddr,
  input  wire logic [15:0] memRdata,
  input  wire logic        termModePin,
  input  wire logic        textModePin,
  input  wire logic        serBusy,
  output logic             conValid,
  input  wire logic        conReady,
  output logic             serValid,
  input  wire logic        serReady,
  output logic      [7:0]  outChar,
  output logic             faultFlag
);
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_PTR   = 6'b000010,
    ST_CHECK = 6'b000100,
    ST_LOAD  = 6'b001000,
    ST_FETCH = 6'b010000,
    ST_SEND  = 6'b100000
  } state_t;

  state_t      state_r;
  state_t      state_nxt;
  logic [3:0]  dest_r;
  logic        indir_r;
  logic [15:0] src_r;
  logic [1:0]  irqSt_r;
  logic [1:0]  mask_r;
  logic        sent_r;
  logic [15:0] base_r;
  logic        rdPend_r;
  logic [4:0]  issue_r;
  logic [3:0]  recv_r;
  logic        nulSeen_r;
  logic [7:0]  last_r;
  logic [5:0]  len_r;
  logic [5:0]  idx_r;
  logic        fetchWait_r;
  logic [15:0] bufRd;
  logic [1:0]  modes;
  logic        termMode;
  logic        textMode;

  pin_sync #(.W(2)) u_sync (
    .clk   (clk),
    .rstn  (rstn),
    .pinIn ({textModePin, termModePin}),
    .level (modes)
  );
  assign termMode = modes[0];
  assign textMode = modes[1];

  // register decode
  wire ctrlWr   = regWr && (regAddr == lmsg_pkg::ADDR_CTRL);
  wire srcWr    = regWr && (regAddr == lmsg_pkg::ADDR_SRC);
  wire irqWr    = regWr && (regAddr == lmsg_pkg::ADDR_IRQ);
  wire maskWr   = regWr && (regAddr == lmsg_pkg::ADDR_MASK);
  wire busy     = (state_r != ST_IDLE);
  wire start    = ctrlWr && regWdata[lmsg_pkg::CTRL_START] && !busy;
  wire [3:0] startDest = regWdata[lmsg_pkg::CTRL_DEST_LSB +: 4];
  wire toCon    = (dest_r == lmsg_pkg::DEST_CONSOLE);
  wire toSerL   = (dest_r == lmsg_pkg::DEST_SER_LEFT);
  wire toSerR   = (dest_r == lmsg_pkg::DEST_SER_RIGHT);
  wire toSer    = toSerL || toSerR;
  wire swap     = toSerR;

  // memory area of a word address, zero when unmapped
  function automatic logic [2:0] areaOf(input logic [16:0] a);
    logic [2:0] r;
    r = 3'h0;
    if (a[16]) r = 3'h0;
    else if (a[15:0] <= lmsg_pkg::IR_END) r = 3'h1;
    else if (a[15:0] >= lmsg_pkg::HR_BASE && a[15:0] <= lmsg_pkg::HR_END) r = 3'h2;
    else if (a[15:0] >= lmsg_pkg::AR_BASE && a[15:0] <= lmsg_pkg::AR_END) r = 3'h3;
    else if (a[15:0] >= lmsg_pkg::LR_BASE && a[15:0] <= lmsg_pkg::LR_END) r = 3'h4;
    else if (a[15:0] >= lmsg_pkg::DATA_BASE && a[15:0] <= lmsg_pkg::DATA_END) r = 3'h5;
    return r;
  endfunction

  wire [2:0]  areaFirst = areaOf({1'b0, base_r});
  wire [2:0]  areaLast  = areaOf({1'b0, base_r} + {1'b0, lmsg_pkg::MSG_SPAN});
  wire        areaBad   = (areaFirst == 3'h0) || (areaFirst != areaLast);
  wire        destBad   = !(toCon || toSer);
  wire        busyBad   = toSer && serBusy;
  wire        checkFault = areaBad || destBad || busyBad;

  // indirect pointer: four BCD digits giving a data memory index
  wire [3:0]  d3 = memRdata[15:12];
  wire [3:0]  d2 = memRdata[11:8];
  wire [3:0]  d1 = memRdata[7:4];
  wire [3:0]  d0 = memRdata[3:0];
  wire        bcdOk = (d3 <= 4'h9) && (d2 <= 4'h9) && (d1 <= 4'h9) && (d0 <= 4'h9);
  wire [15:0] ptrBin = 16'(16'(d3) * 16'h03E8) + 16'(16'(d2) * 16'h0064)
                     + 16'(16'(d1) * 16'h000A) + 16'(d0);
  wire        ptrOk = bcdOk && (ptrBin < lmsg_pkg::DATA_WORDS);
  wire        ptrFault = (state_r == ST_PTR) && rdPend_r && !ptrOk;

  // scan of one received word in send order
  wire [7:0]  b0 = swap ? memRdata[7:0] : memRdata[15:8];
  wire [7:0]  b1 = swap ? memRdata[15:8] : memRdata[7:0];
  wire        loadRx = (state_r == ST_LOAD) && rdPend_r;
  wire        b0Nul = (b0 == lmsg_pkg::CHAR_NUL);
  wire        b1Nul = (b1 == lmsg_pkg::CHAR_NUL);
  wire        scanNul = nulSeen_r || b0Nul || b1Nul;
  wire [5:0]  scanLen = nulSeen_r ? len_r :
                        b0Nul ? len_r :
                        b1Nul ? len_r + 6'h01 : len_r + 6'h02;
  wire [7:0]  scanLast = (nulSeen_r || b0Nul) ? last_r : (b1Nul ? b0 : b1);
  wire        loadDone = loadRx && (recv_r == lmsg_pkg::MSG_LAST_WORD[3:0]);
  wire        crOk = (scanLast == lmsg_pkg::CHAR_CR) && (scanLen != 6'h00);
  wire        modeOk = (toCon && termMode) || (toSer && textMode);
  wire        goSend = loadDone && crOk && modeOk;

  // character output handshake
  wire        outReady = toCon ? conReady : serReady;
  wire        charTaken = (state_r == ST_SEND) && outReady;
  wire        lastChar = (idx_r + 6'h01 == len_r);
  wire [7:0]  selByte = (idx_r[0] == swap) ? bufRd[15:8] : bufRd[7:0];
  wire        finish = ptrFault || ((state_r == ST_CHECK) && checkFault)
                     || (loadDone && !goSend) || (charTaken && lastChar);
  wire        faultEv = ptrFault || ((state_r == ST_CHECK) && checkFault);

  assign conValid = (state_r == ST_SEND) && toCon;
  assign serValid = (state_r == ST_SEND) && toSer;
  assign irq      = |(irqSt_r & mask_r);

  msg_buf u_buf (
    .clk    (clk),
    .wrEn   (loadRx),
    .wrAddr (recv_r),
    .wrData (memRdata),
    .rdAddr (idx_r[4:1]),
    .rdData (bufRd)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start) state_nxt = regWdata[lmsg_pkg::CTRL_INDIR] ? ST_PTR : ST_CHECK;
      end
      ST_PTR: begin
        if (rdPend_r) state_nxt = ptrOk ? ST_CHECK : ST_IDLE;
      end
      ST_CHECK: begin
        state_nxt = checkFault ? ST_IDLE : ST_LOAD;
      end
      ST_LOAD: begin
        if (loadDone) state_nxt = goSend ? ST_FETCH : ST_IDLE;
      end
      ST_FETCH: begin
        if (fetchWait_r) state_nxt = ST_SEND;
      end
      ST_SEND: begin
        if (charTaken) state_nxt = lastChar ? ST_IDLE : ST_FETCH;
      end
    endcase
  end

  // software registers and interrupt status
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dest_r  <= lmsg_pkg::RST_DEST;
      indir_r <= 1'b0;
      src_r   <= lmsg_pkg::RST_SRC;
      mask_r  <= lmsg_pkg::RST_MASK;
      irqSt_r <= 2'h0;
    end else begin
      if (start) begin
        dest_r  <= startDest;
        indir_r <= regWdata[lmsg_pkg::CTRL_INDIR];
      end
      if (srcWr && !busy) src_r <= regWdata;
      if (maskWr) mask_r <= regWdata[1:0];
      irqSt_r <= (irqSt_r & ~(irqWr ? regWdata[1:0] : 2'h0))
               | {faultEv, finish};
    end
  end

  // read port, data in the cycle after the strobe only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 16'h0000;
    end else if (!regRd) begin
      regRdata <= 16'h0000;
    end else begin
      unique case (regAddr)
        lmsg_pkg::ADDR_CTRL: regRdata <= {8'h00, dest_r, 2'h0, indir_r, 1'b0};
        lmsg_pkg::ADDR_SRC:  regRdata <= src_r;
        lmsg_pkg::ADDR_STAT: regRdata <= {2'h0, len_r, 5'h00, sent_r, faultFlag, busy};
        lmsg_pkg::ADDR_IRQ:  regRdata <= {14'h0000, irqSt_r};
        lmsg_pkg::ADDR_MASK: regRdata <= {14'h0000, mask_r};
        default:             regRdata <= 16'h0000;
      endcase
    end
  end

  // engine datapath
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r     <= ST_IDLE;
      base_r      <= 16'h0000;
      memRd       <= 1'b0;
      memAddr     <= 16'h0000;
      rdPend_r    <= 1'b0;
      issue_r     <= 5'h00;
      recv_r      <= 4'h0;
      nulSeen_r   <= 1'b0;
      last_r      <= 8'h00;
      len_r       <= 6'h00;
      idx_r       <= 6'h00;
      fetchWait_r <= 1'b0;
      outChar     <= 8'h00;
      faultFlag   <= 1'b0;
      sent_r      <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      rdPend_r <= memRd;
      memRd    <= 1'b0;
      if (start) begin
        faultFlag <= 1'b0;
        sent_r    <= 1'b0;
        issue_r   <= 5'h00;
        recv_r    <= 4'h0;
        nulSeen_r <= 1'b0;
        last_r    <= 8'h00;
        len_r     <= 6'h00;
        idx_r     <= 6'h00;
        if (regWdata[lmsg_pkg::CTRL_INDIR]) begin
          memRd   <= 1'b1;
          memAddr <= lmsg_pkg::DATA_BASE + src_r;
        end else begin
          base_r  <= src_r;
        end
      end
      if (state_r == ST_PTR && rdPend_r) begin
        base_r <= lmsg_pkg::DATA_BASE + ptrBin;
      end
      if (faultEv) faultFlag <= 1'b1;
      // sixteen reads, one per cycle
      if (state_r == ST_LOAD && issue_r <= lmsg_pkg::MSG_LAST_WORD) begin
        memRd   <= 1'b1;
        memAddr <= base_r + 16'(issue_r);
        issue_r <= issue_r + 5'h01;
      end
      if (loadRx) begin
        recv_r    <= recv_r + 4'h1;
        nulSeen_r <= scanNul;
        len_r     <= scanLen;
        last_r    <= scanLast;
      end
      if (state_r == ST_FETCH) begin
        fetchWait_r <= !fetchWait_r;
        if (fetchWait_r) outChar <= selByte;
      end
      if (charTaken) begin
        idx_r  <= idx_r + 6'h01;
        sent_r <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_len_max;
    len_r <= lmsg_pkg::MSG_CHARS;
  endproperty
  a_len_max: assert property (p_len_max) else $error("message length above 32");

  property p_area;
    (state_r == ST_CHECK) && areaBad |=> faultFlag && (state_r == ST_IDLE) && !sent_r;
  endproperty
  a_area: assert property (p_area) else $error("area split without fault");

  property p_no_nul;
    (conValid || serValid) |-> (outChar != lmsg_pkg::CHAR_NUL);
  endproperty
  a_no_nul: assert property (p_no_nul) else $error("null character sent");

  property p_cr_last;
    (state_r == ST_SEND) && lastChar |-> (outChar == lmsg_pkg::CHAR_CR);
  endproperty
  a_cr_last: assert property (p_cr_last) else $error("last character not CR");

  property p_console;
    conValid |-> (dest_r == lmsg_pkg::DEST_CONSOLE) && termMode && !serValid;
  endproperty
  a_console: assert property (p_console) else $error("console output misrouted");

  property p_serial;
    serValid |-> toSer && textMode && !conValid;
  endproperty
  a_serial: assert property (p_serial) else $error("serial output misrouted");

  property p_right_first;
    (state_r == ST_FETCH) && fetchWait_r && toSerR && (idx_r[0] == 1'b0)
      |=> (outChar == $past(bufRd[7:0]));
  endproperty
  a_right_first: assert property (p_right_first) else $error("rightmost byte not first");

  property p_no_mode;
    loadDone && crOk && !modeOk |=> (state_r == ST_IDLE) && !conValid && !serValid;
  endproperty
  a_no_mode: assert property (p_no_mode) else $error("output without active mode");

  property p_ptr;
    ptrFault |=> faultFlag && (state_r == ST_IDLE);
  endproperty
  a_ptr: assert property (p_ptr) else $error("bad pointer without fault");

  property p_busy;
    (state_r == ST_CHECK) && toSer && serBusy |=> faultFlag ##1 !serValid;
  endproperty
  a_busy: assert property (p_busy) else $error("busy serial buffer not faulted");

  property p_left_first;
    (state_r == ST_FETCH) && fetchWait_r && !swap && (idx_r[0] == 1'b0)
      |=> (outChar == $past(bufRd[15:8]));
  endproperty
  a_left_first: assert property (p_left_first) else $error("high byte not first");

  property p_fault_quiet;
    faultFlag |-> !conValid && !serValid && !sent_r;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet) else $error("characters sent on fault");

  c_console: cover property (conValid && conReady && lastChar);
  c_serial:  cover property (serValid && serReady && lastChar && toSerR);
  c_fault:   cover property ($rose(faultFlag));
  c_no_cr:   cover property (loadDone && !crOk);
endmodule // long_text_output

// ### far_side_model.sv
// memory, console and serial terminal on the far side of the long text output block
`timescale 1ns/1ns
module far_side_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        slow,
  input  wire logic        memRd,
  input  wire logic [15:0] memAddr,
  output logic      [15:0] memRdata,
  input  wire logic        conValid,
  input  wire logic        serValid,
  input  wire logic [7:0]  outChar,
  output logic             conReady,
  output logic             serReady
);
  logic [15:0] mem [0:8191];
  logic [7:0]  conQ [$];
  logic [7:0]  serQ [$];
  logic [7:0]  lastCon;
  logic [1:0]  pace;
  int          reads = 0;
  int          clears = 0;
  // stalls three cycles in four when slow
  assign conReady = !slow || pace == 2'h3;
  assign serReady = !slow || pace == 2'h1;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      memRdata <= 16'h0000;
      pace <= 2'h0;
      lastCon <= 8'h00;
    end else begin
      pace <= pace + 2'h1;
      // no stale word between reads
      memRdata <= memRd ? mem[memAddr[12:0]] : ~memRdata;
      if (memRd) reads <= reads + 1;
      if (conValid && conReady) begin
        conQ.push_back(outChar);
        lastCon <= outChar;
        if (outChar == 8'h0D && lastCon == 8'h0D) begin
          clears <= clears + 1;
          lastCon <= 8'h00;
        end
      end
      if (serValid && serReady) serQ.push_back(outChar);
    end
  end
endmodule // far_side_model

// ### long_text_output_test.sv
// self-checking bench of the long text output block
`timescale 1ns/1ns
module long_text_output_test;
  typedef logic [7:0] bq_t [$];
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [15:0] regRdata;
  logic        irq;
  logic        memRd;
  logic [15:0] memAddr;
  logic [15:0] memRdata;
  logic        termModePin = 1'b0;
  logic        textModePin = 1'b0;
  logic        serBusy = 1'b0;
  logic        conValid;
  logic        conReady;
  logic        serValid;
  logic        serReady;
  logic [7:0]  outChar;
  logic        faultFlag;
  logic        slow = 1'b0;
  logic [15:0] maskV = 16'h0000;
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #5 clk = ~clk;
  long_text_output u_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq), .memRd(memRd),
    .memAddr(memAddr), .memRdata(memRdata), .termModePin(termModePin),
    .textModePin(textModePin), .serBusy(serBusy), .conValid(conValid), .conReady(conReady),
    .serValid(serValid), .serReady(serReady), .outChar(outChar), .faultFlag(faultFlag));
  far_side_model u_far (.clk(clk), .rstn(rstn), .slow(slow), .memRd(memRd),
    .memAddr(memAddr), .memRdata(memRdata), .conValid(conValid), .serValid(serValid),
    .outChar(outChar), .conReady(conReady), .serReady(serReady));
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic modes(input logic t, input logic x);
    @(posedge clk);
    termModePin <= t;
    textModePin <= x;
    repeat (6) @(posedge clk);
  endtask
  // chars in send order, cut at null, kept only if a CR ends them
  function automatic bq_t expect_of(bq_t b, logic sw);
    bq_t s;
    bq_t e;
    for (int i = 0; i < 32; i++) s.push_back(sw ? b[i ^ 1] : b[i]);
    for (int i = 0; i < 32 && s[i] !== 8'h00; i++) e.push_back(s[i]);
    if (e.size() == 0 || e[e.size() - 1] !== 8'h0D) e.delete();
    return e;
  endfunction
  task automatic cmpq(input bq_t seen, input bq_t e, input logic on);
    if (!on) e.delete();
    check(16'(seen.size()), 16'(e.size()));
    foreach (e[i]) if (i < seen.size()) check({8'h00, seen[i]}, {8'h00, e[i]});
  endtask
  task automatic run(input logic [3:0] dest, input logic ind, input logic [15:0] src,
                     input logic [15:0] base, input bq_t b, input int sel, input logic flt);
    bq_t e;
    logic [15:0] v;
    int n;
    while (b.size() < 32) b.push_back(8'h00);
    for (int i = 0; i < 16; i++) u_far.mem[base[12:0] + 13'(i)] = {b[2*i], b[2*i+1]};
    e = expect_of(b, dest == lmsg_pkg::DEST_SER_RIGHT);
    u_far.conQ.delete();
    u_far.serQ.delete();
    u_far.reads = 0;
    wr(lmsg_pkg::ADDR_SRC, src);
    wr(lmsg_pkg::ADDR_CTRL, {8'h00, dest, 2'b00, ind, 1'b1});
    n = 0;
    v = 16'h0000;
    while (v[lmsg_pkg::IRQ_DONE] !== 1'b1 && n < 400) begin
      rd(lmsg_pkg::ADDR_IRQ, v);
      n++;
    end
    check(v, {14'h0000, flt, 1'b1});
    check({15'h0000, faultFlag}, {15'h0000, flt});
    check({15'h0000, irq}, {15'h0000, |(maskV[1:0] & {flt, 1'b1})});
    cmpq(u_far.conQ, e, sel == 1);
    cmpq(u_far.serQ, e, sel == 2);
    wr(lmsg_pkg::ADDR_IRQ, 16'h0003);
    #1 check({15'h0000, irq}, 16'h0000);
  endtask
  task automatic t_reset();
    logic [15:0] v;
    rd(lmsg_pkg::ADDR_SRC, v);
    check(v, lmsg_pkg::RST_SRC);
    rd(lmsg_pkg::ADDR_MASK, v);
    check(v, 16'h0000);
    rd(lmsg_pkg::ADDR_STAT, v);
    check(v, 16'h0000);
    wr(4'h9, 16'hFFFF);
    rd(4'h9, v);
    check(v, 16'h0000);
  endtask
  task automatic t_console();
    logic [15:0] v;
    modes(1'b1, 1'b0);
    run(lmsg_pkg::DEST_CONSOLE, 1'b0, lmsg_pkg::DATA_BASE, lmsg_pkg::DATA_BASE,
        '{8'h41, 8'h42, 8'h0D, 8'h0D, 8'h00, 8'h5A, 8'h5A}, 1, 1'b0);
    check(16'(u_far.clears), 16'h0001);
    // length four, something sent, no fault, idle
    rd(lmsg_pkg::ADDR_STAT, v);
    check(v, 16'h0404);
  endtask
  task automatic t_ser_left();
    bq_t b;
    for (int i = 0; i < 31; i++) b.push_back(8'(8'h07 + 3 * i));
    b.push_back(8'h0D);
    modes(1'b0, 1'b1);
    @(posedge clk);
    slow <= 1'b1;
    run(lmsg_pkg::DEST_SER_LEFT, 1'b0, lmsg_pkg::HR_BASE, lmsg_pkg::HR_BASE, b, 2, 1'b0);
    check(16'(u_far.reads), 16'h0010);
    @(posedge clk);
    slow <= 1'b0;
  endtask
  task automatic t_ser_right();
    modes(1'b0, 1'b1);
    run(lmsg_pkg::DEST_SER_RIGHT, 1'b0, lmsg_pkg::LR_BASE, lmsg_pkg::LR_BASE,
        '{8'h42, 8'h41, 8'h0D, 8'h43, 8'h00, 8'h00, 8'h5A, 8'h5A}, 2, 1'b0);
  endtask
  task automatic t_no_cr();
    modes(1'b1, 1'b0);
    run(lmsg_pkg::DEST_CONSOLE, 1'b0, lmsg_pkg::AR_BASE, lmsg_pkg::AR_BASE,
        '{8'h41, 8'h42, 8'h00, 8'h0D}, 1, 1'b0);
  endtask
  task automatic t_area();
    logic [15:0] v;
    modes(1'b1, 1'b0);
    run(lmsg_pkg::DEST_CONSOLE, 1'b0, 16'h00F5, 16'h00F5, '{8'h41, 8'h0D}, 0, 1'b1);
    // fault only: nothing sent, no length
    rd(lmsg_pkg::ADDR_STAT, v);
    check(v, 16'h0002);
    // undefined destination code faults too
    run(4'h3, 1'b0, lmsg_pkg::HR_BASE, lmsg_pkg::HR_BASE, '{8'h41, 8'h0D}, 0, 1'b1);
  endtask
  task automatic t_indirect();
    logic [15:0] bad [2];
    bad = '{16'h00A0, 16'h2048};
    modes(1'b0, 1'b1);
    u_far.mem[13'h1005] = 16'h0010;
    run(lmsg_pkg::DEST_SER_LEFT, 1'b1, 16'h0005, 16'h100A, '{8'h41, 8'h0D}, 2, 1'b0);
    foreach (bad[i]) begin
      u_far.mem[13'h1005] = bad[i];
      run(lmsg_pkg::DEST_SER_LEFT, 1'b1, 16'h0005, 16'h1100, '{8'h41, 8'h0D}, 0, 1'b1);
    end
  endtask
  task automatic t_busy();
    modes(1'b0, 1'b1);
    @(posedge clk);
    serBusy <= 1'b1;
    run(lmsg_pkg::DEST_SER_LEFT, 1'b0, lmsg_pkg::HR_BASE, lmsg_pkg::HR_BASE,
        '{8'h41, 8'h0D}, 0, 1'b1);
    @(posedge clk);
    serBusy <= 1'b0;
  endtask
  task automatic t_no_mode();
    modes(1'b0, 1'b0);
    wr(lmsg_pkg::ADDR_MASK, 16'h0001);
    maskV = 16'h0001;
    run(lmsg_pkg::DEST_CONSOLE, 1'b0, lmsg_pkg::DATA_BASE, lmsg_pkg::DATA_BASE,
        '{8'h41, 8'h0D}, 0, 1'b0);
    run(lmsg_pkg::DEST_SER_LEFT, 1'b0, lmsg_pkg::DATA_BASE, lmsg_pkg::DATA_BASE,
        '{8'h41, 8'h0D}, 0, 1'b0);
    modes(1'b0, 1'b1);
    run(lmsg_pkg::DEST_CONSOLE, 1'b0, lmsg_pkg::DATA_BASE, lmsg_pkg::DATA_BASE,
        '{8'h41, 8'h0D}, 0, 1'b0);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_console();
    t_ser_left();
    t_ser_right();
    t_no_cr();
    t_area();
    t_indirect();
    t_busy();
    t_no_mode();
    give_verdict();
  end
endmodule // long_text_output_test
